// ==== mfr_regs.svh ====
// opcodes, phase lengths and wrap codes of the multi-line read engine
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH
`define MFR_OP_DUAL_OUT 8'h3B
`define MFR_OP_QUAD_OUT 8'h6B
`define MFR_OP_QUAD_IO 8'hEB
`define MFR_OP_QUAD_IO_SD 8'hE7
`define MFR_OP_FAST 8'h0B
`define MFR_CMD_CLKS_SPI 5'h08
`define MFR_CMD_CLKS_QPI 5'h02
`define MFR_ADDR_CLKS_X1 5'h18
`define MFR_ADDR_CLKS_X2 5'h0C
`define MFR_ADDR_CLKS_X4 5'h06
`define MFR_IND_CLKS 5'h02
`define MFR_DUMMY_X1 5'h08
`define MFR_DUMMY_DIO 5'h04
`define MFR_DUMMY_QIO 5'h04
`define MFR_DUMMY_AFTER_IND 5'h02
`define MFR_WRAP_OFF_HI 4'h1
`define MFR_WRAP_MAX_CODE 8'h03
`define MFR_WRAP_MASK_8 6'h07
`define MFR_WRAP_MASK_16 6'h0F
`define MFR_WRAP_MASK_32 6'h1F
`define MFR_WRAP_MASK_64 6'h3F
`define MFR_SYNC_RST 6'h20
`endif

// ==== mfr_pkg.sv ====
// types of the multi-line read engine
`default_nettype none
package mfr_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_CMD = 8'h02,
        ST_ADDR = 8'h04,
        ST_MODE = 8'h08,
        ST_DUMMY = 8'h10,
        ST_DATA = 8'h20,
        ST_WRAP = 8'h40,
        ST_SKIP = 8'h80
    } mfr_state_e;
    typedef logic [2:0] mfr_lanes_t;
    typedef struct packed {
        logic ok;
        mfr_lanes_t addr_w;
        mfr_lanes_t data_w;
        logic ind;
        logic [4:0] dummy;
        logic wrap;
    } mfr_prof_s;
endpackage : mfr_pkg
`default_nettype wire

// ==== mfr_stream_if.sv ====
// byte stream between the read engine and its two-entry buffer
`timescale 1ns/10ps
`default_nettype none
interface mfr_stream_if #(parameter int W = 8) ();
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic flush;
    modport core (output in_valid, output in_data, output out_ready,
        output flush, input in_ready, input out_valid, input out_data);
    modport fifo (input in_valid, input in_data, input out_ready,
        input flush, output in_ready, output out_valid, output out_data);
endinterface : mfr_stream_if
`default_nettype wire

// ==== mfr_pair_buf.sv ====
// small fifo holding prefetched array bytes
`timescale 1ns/10ps
`default_nettype none
module mfr_pair_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    mfr_stream_if.fifo s
);
    localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("buffer depth below two");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign s.in_ready = (cnt_r != FULL);
    assign s.out_valid = (cnt_r != '0);
    assign s.out_data = mem_r[rd_r];
    assign push = s.in_valid && s.in_ready;
    assign pop = s.out_valid && s.out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (s.flush) begin
            wr_nxt = '0;
            rd_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                mem_nxt[wr_r] = s.in_data;
                wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_nxt = cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule : mfr_pair_buf
`default_nettype wire

// ==== mfr_read_engine.sv ====
// multi-line read engine of a serial nor flash, device side
// Notes on behaviour
// - 3Bh: opcode, address on one line, eight dummies, data on two lines.
// - dual-io: address two bits per clock, four dummies, two-bit data.
// - 6Bh: opcode, address on one line, eight dummies, four-bit data.
// - EBh: address four bits per clock, two indicator plus four dummies.
// - inputs sampled on sclk rise, outputs change on sclk fall.
// - any start address, +1 per byte, wraps to zero at top.
// - chip select high ends the read and releases the lines.
// - reads refused while an internal write cycle runs; an enhance-mode access starts at address and is not refused.
// - EBh also accepted in four-line command mode.
// - toggling indicator nibbles keep enhance mode; next access skips opcode.
// - non-toggling indicator leaves enhance mode at once; next access needs opcode.
// - enhance only for EBh/E7h single-line and EBh/0Bh four-line.
// - in enhance, first clocks after select falls are address.
// - all-ones indicator also ends enhance mode.
// - E7h uses four clocks after address in total.
// - wrapping off after reset, on once a length is set.
// - codes 00h-03h give 8/16/32/64 bytes; 1xh turns wrap off.
// - wrapped reads stay in the aligned block holding the start.
// - wrap applies to 0Bh/EBh four-line, EBh/E7h single-line.
// - length opcode: 8 clocks or 2 clocks; upper lines ignored single-line.
`include "mfr_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module mfr_read_engine #(
    parameter int ADDR_W = 24,
    parameter logic [7:0] OP_DUAL_IO = 8'hBB,
    parameter logic [7:0] OP_BURST = 8'hC0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic four_line_mode,
    input wire logic write_busy,
    output logic arr_rd_en,
    output logic [ADDR_W-1:0] arr_rd_addr,
    input wire logic [7:0] arr_rd_data,
    output logic enhance_active,
    output logic wrap_enable
);
    if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_addr
        $error("address width must be 8 to 24");
    end

    function automatic mfr_pkg::mfr_prof_s prof_of(input logic [7:0] op,
        input logic four_line_command_mode);
        mfr_pkg::mfr_prof_s p;
        p = '0;
        p.addr_w = 3'h4;
        p.data_w = 3'h4;
        if (!four_line_command_mode && op == `MFR_OP_DUAL_OUT) begin
            p.ok = 1'b1;
            p.addr_w = 3'h1;
            p.data_w = 3'h2;
            p.dummy = `MFR_DUMMY_X1;
        end else if (!four_line_command_mode && op == OP_DUAL_IO) begin
            p.ok = 1'b1;
            p.addr_w = 3'h2;
            p.data_w = 3'h2;
            p.dummy = `MFR_DUMMY_DIO;
        end else if (!four_line_command_mode && op == `MFR_OP_QUAD_OUT) begin
            p.ok = 1'b1;
            p.addr_w = 3'h1;
            p.dummy = `MFR_DUMMY_X1;
        end else if (op == `MFR_OP_QUAD_IO) begin
            p.ok = 1'b1;
            p.ind = 1'b1;
            p.dummy = `MFR_DUMMY_QIO;
            p.wrap = 1'b1;
        end else if (!four_line_command_mode && op == `MFR_OP_QUAD_IO_SD) begin
            p.ok = 1'b1;
            p.ind = 1'b1;
            p.dummy = `MFR_DUMMY_AFTER_IND;
            p.wrap = 1'b1;
        end else if (four_line_command_mode && op == `MFR_OP_FAST) begin
            p.ok = 1'b1;
            p.ind = 1'b1;
            p.dummy = `MFR_DUMMY_AFTER_IND;
            p.wrap = 1'b1;
        end
        return p;
    endfunction : prof_of

    function automatic logic [23:0] shin(input logic [23:0] s,
        input logic [3:0] d, input mfr_pkg::mfr_lanes_t w);
        unique case (w)
            3'h4: shin = {s[19:0], d};
            3'h2: shin = {s[21:0], d[1:0]};
            default: shin = {s[22:0], d[0]};
        endcase
    endfunction : shin

    function automatic logic [4:0] addr_clks(input mfr_pkg::mfr_lanes_t w);
        unique case (w)
            3'h4: addr_clks = `MFR_ADDR_CLKS_X4;
            3'h2: addr_clks = `MFR_ADDR_CLKS_X2;
            default: addr_clks = `MFR_ADDR_CLKS_X1;
        endcase
    endfunction : addr_clks

    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a, input logic wr, input logic [5:0] m);
        logic [ADDR_W-1:0] msk;
        logic [ADDR_W-1:0] inc;
        msk = wr ? {{(ADDR_W-6){1'b0}}, m} : '1;
        inc = a + 1'b1;
        next_addr = (a & ~msk) | (inc & msk);
    endfunction : next_addr

    // pin synchronisers: cs_n, sclk, io[3:0]
    logic [5:0] pins, s1_r, s2_r, s3_r, flt_r, flt_nxt, prev_r;
    assign pins = {cs_n, sclk, io_in};
    for (genvar i = 0; i < 6; i++) begin : g_filt
        assign flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= `MFR_SYNC_RST;
            s2_r <= `MFR_SYNC_RST;
            s3_r <= `MFR_SYNC_RST;
            flt_r <= `MFR_SYNC_RST;
            prev_r <= `MFR_SYNC_RST;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            prev_r <= flt_r;
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic [3:0] bits;
    assign sclk_rise = flt_r[4] && !prev_r[4];
    assign sclk_fall = !flt_r[4] && prev_r[4];
    assign cs_fall = prev_r[5] && !flt_r[5];
    assign cs_rise = !prev_r[5] && flt_r[5];
    assign bits = flt_r[3:0];

    mfr_stream_if #(.W(8)) bf ();
    mfr_pair_buf #(.W(8), .DEPTH(2)) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .s(bf.fifo)
    );

    mfr_pkg::mfr_state_e st_r, st_nxt;
    mfr_pkg::mfr_prof_s prof_r, prof_nxt, prof_dec;
    logic [4:0] cnt_r, cnt_nxt, need;
    logic [23:0] sh_r, sh_nxt, sh_n;
    logic [ADDR_W-1:0] fa_r, fa_nxt;
    logic [7:0] osh_r, osh_nxt;
    logic [1:0] ocnt_r, ocnt_nxt;
    logic [3:0] io_out_r, io_out_nxt, oe_r, oe_nxt;
    logic enh_r, enh_nxt, wen_r, wen_nxt, fon_r, fon_nxt, pend_r, pend_nxt;
    logic [5:0] wmask_r, wmask_nxt;
    logic cmd_end, op_read, toggle, issue, wrap_act, last_clk;
    mfr_pkg::mfr_lanes_t cmd_w;

    assign cmd_w = four_line_mode ? 3'h4 : 3'h1;
    assign wrap_act = wen_r && prof_r.wrap;
    assign issue = fon_r && bf.in_ready && !pend_r && !cs_rise
        && !flt_r[5];
    assign bf.in_valid = pend_r && !cs_rise;
    assign bf.in_data = arr_rd_data;
    assign bf.flush = cs_rise;
    assign bf.out_ready = sclk_fall && st_r == mfr_pkg::ST_DATA
        && ocnt_r == 2'h0;
    assign prof_dec = prof_of(sh_n[7:0], four_line_mode);
    assign op_read = prof_dec.ok;
    assign toggle = (sh_n[7:4] == ~sh_n[3:0]);

    always_comb begin
        st_nxt = st_r;
        prof_nxt = prof_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        fa_nxt = fa_r;
        osh_nxt = osh_r;
        ocnt_nxt = ocnt_r;
        io_out_nxt = io_out_r;
        oe_nxt = oe_r;
        enh_nxt = enh_r;
        wen_nxt = wen_r;
        wmask_nxt = wmask_r;
        fon_nxt = fon_r;
        pend_nxt = issue;
        need = 5'h01;
        sh_n = sh_r;
        cmd_end = 1'b0;
        unique case (st_r)
            mfr_pkg::ST_CMD, mfr_pkg::ST_WRAP: begin
                need = four_line_mode ? `MFR_CMD_CLKS_QPI : `MFR_CMD_CLKS_SPI;
                sh_n = shin(sh_r, bits, cmd_w);
            end
            mfr_pkg::ST_ADDR: begin
                need = addr_clks(prof_r.addr_w);
                sh_n = shin(sh_r, bits, prof_r.addr_w);
            end
            mfr_pkg::ST_MODE: begin
                need = `MFR_IND_CLKS;
                sh_n = shin(sh_r, bits, 3'h4);
            end
            mfr_pkg::ST_DUMMY: need = prof_r.dummy;
            mfr_pkg::ST_IDLE, mfr_pkg::ST_DATA, mfr_pkg::ST_SKIP: ;
        endcase
        last_clk = sclk_rise && (cnt_r + 5'h01 == need);
        if (issue) begin
            fa_nxt = next_addr(fa_r, wrap_act, wmask_r);
        end
        if (sclk_rise && st_r != mfr_pkg::ST_IDLE) begin
            sh_nxt = sh_n;
            cnt_nxt = cnt_r + 5'h01;
        end
        unique case (st_r)
            mfr_pkg::ST_IDLE: begin
                if (cs_fall) begin
                    st_nxt = enh_r ? mfr_pkg::ST_ADDR : mfr_pkg::ST_CMD;
                    cnt_nxt = '0;
                    sh_nxt = '0;
                end
            end
            mfr_pkg::ST_CMD: begin
                if (last_clk) begin
                    cmd_end = 1'b1;
                    cnt_nxt = '0;
                    if (sh_n[7:0] == OP_BURST) begin
                        st_nxt = mfr_pkg::ST_WRAP;
                    end else if (op_read && !write_busy) begin
                        st_nxt = mfr_pkg::ST_ADDR;
                        prof_nxt = prof_dec;
                    end else begin
                        st_nxt = mfr_pkg::ST_SKIP;
                    end
                end
            end
            mfr_pkg::ST_ADDR: begin
                if (last_clk) begin
                    cnt_nxt = '0;
                    fa_nxt = sh_n[ADDR_W-1:0];
                    fon_nxt = 1'b1;
                    st_nxt = prof_r.ind ? mfr_pkg::ST_MODE : mfr_pkg::ST_DUMMY;
                end
            end
            mfr_pkg::ST_MODE: begin
                if (last_clk) begin
                    cnt_nxt = '0;
                    enh_nxt = toggle;
                    st_nxt = mfr_pkg::ST_DUMMY;
                end
            end
            mfr_pkg::ST_DUMMY: begin
                if (last_clk) begin
                    ocnt_nxt = 2'h0;
                    st_nxt = mfr_pkg::ST_DATA;
                end
            end
            mfr_pkg::ST_DATA: begin
                if (sclk_fall) begin
                    oe_nxt = (prof_r.data_w == 3'h4) ? 4'hF : 4'h3;
                    if (ocnt_r == 2'h0) begin
                        ocnt_nxt = (prof_r.data_w == 3'h4) ? 2'h1 : 2'h3;
                        if (bf.out_valid) begin
                            osh_nxt = bf.out_data;
                        end else begin
                            osh_nxt = '0;
                        end
                    end else begin
                        ocnt_nxt = ocnt_r - 2'h1;
                    end
                    if (prof_r.data_w == 3'h4) begin
                        io_out_nxt = osh_nxt[7:4];
                        osh_nxt = {osh_nxt[3:0], 4'h0};
                    end else begin
                        io_out_nxt = {2'h0, osh_nxt[7:6]};
                        osh_nxt = {osh_nxt[5:0], 2'h0};
                    end
                end
            end
            mfr_pkg::ST_WRAP: begin
                if (last_clk) begin
                    st_nxt = mfr_pkg::ST_SKIP;
                    if (sh_n[7:4] == `MFR_WRAP_OFF_HI) begin
                        wen_nxt = 1'b0;
                    end else if (sh_n[7:0] <= `MFR_WRAP_MAX_CODE) begin
                        wen_nxt = 1'b1;
                        unique case (sh_n[1:0])
                            2'h0: wmask_nxt = `MFR_WRAP_MASK_8;
                            2'h1: wmask_nxt = `MFR_WRAP_MASK_16;
                            2'h2: wmask_nxt = `MFR_WRAP_MASK_32;
                            2'h3: wmask_nxt = `MFR_WRAP_MASK_64;
                        endcase
                    end
                end
            end
            mfr_pkg::ST_SKIP: ;
        endcase
        if (cs_rise) begin
            st_nxt = mfr_pkg::ST_IDLE;
            oe_nxt = 4'h0;
            fon_nxt = 1'b0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= mfr_pkg::ST_IDLE;
            prof_r <= '0;
            cnt_r <= '0;
            sh_r <= '0;
            fa_r <= '0;
            osh_r <= '0;
            ocnt_r <= '0;
            io_out_r <= '0;
            oe_r <= '0;
            enh_r <= 1'b0;
            wen_r <= 1'b0;
            wmask_r <= `MFR_WRAP_MASK_8;
            fon_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            prof_r <= prof_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            fa_r <= fa_nxt;
            osh_r <= osh_nxt;
            ocnt_r <= ocnt_nxt;
            io_out_r <= io_out_nxt;
            oe_r <= oe_nxt;
            enh_r <= enh_nxt;
            wen_r <= wen_nxt;
            wmask_r <= wmask_nxt;
            fon_r <= fon_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign io_out = io_out_r;
    assign io_oe = oe_r;
    assign arr_rd_en = issue;
    assign arr_rd_addr = fa_r;
    assign enhance_active = enh_r;
    assign wrap_enable = wen_r;

    property p_release;
        @(posedge clk) disable iff (!arst_n) cs_rise |=> io_oe == 4'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("output enable still set after select rise");
    property p_busy;
        @(posedge clk) disable iff (!arst_n)
            cmd_end && op_read && write_busy && sh_n[7:0] != OP_BURST
            && !cs_rise |=> st_r == mfr_pkg::ST_SKIP;
    endproperty
    a_busy: assert property (p_busy)
        else $error("read accepted during write cycle");
    property p_out_fall;
        @(posedge clk) disable iff (!arst_n)
            $changed(io_out_r) |-> $past(sclk_fall);
    endproperty
    a_out_fall: assert property (p_out_fall)
        else $error("output changed away from sclk fall");
    property p_enh_keep;
        @(posedge clk) disable iff (!arst_n)
            st_r == mfr_pkg::ST_MODE && last_clk && toggle |=> enh_r;
    endproperty
    a_enh_keep: assert property (p_enh_keep)
        else $error("toggling indicator did not keep enhance");
    property p_enh_exit;
        @(posedge clk) disable iff (!arst_n)
            st_r == mfr_pkg::ST_MODE && last_clk && !toggle |=> !enh_r;
    endproperty
    a_enh_exit: assert property (p_enh_exit)
        else $error("non-toggling indicator kept enhance");
    property p_enh_addr;
        @(posedge clk) disable iff (!arst_n)
            st_r == mfr_pkg::ST_IDLE && cs_fall && enh_r
            |=> st_r == mfr_pkg::ST_ADDR ##1 enh_r;
    endproperty
    a_enh_addr: assert property (p_enh_addr)
        else $error("enhance access did not start at address");
    property p_wrap_set;
        @(posedge clk) disable iff (!arst_n)
            st_r == mfr_pkg::ST_WRAP && last_clk && sh_n[7:0] == 8'h02
            && !cs_rise |=> wen_r && wmask_r == `MFR_WRAP_MASK_32;
    endproperty
    a_wrap_set: assert property (p_wrap_set)
        else $error("wrap code 02h not applied");
    property p_inc;
        @(posedge clk) disable iff (!arst_n)
            issue && !wrap_act |=> fa_r == $past(fa_r) + 1'b1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("address did not advance by one");
    property p_block;
        @(posedge clk) disable iff (!arst_n)
            issue && wrap_act |=> (fa_r[5:0] & ~$past(wmask_r))
            == ($past(fa_r[5:0]) & ~$past(wmask_r));
    endproperty
    a_block: assert property (p_block)
        else $error("wrapped address left its block");
    property p_stall;
        @(posedge clk) disable iff (!arst_n) !bf.in_ready |-> !arr_rd_en;
    endproperty
    a_stall: assert property (p_stall)
        else $error("fetch issued into full buffer");
endmodule : mfr_read_engine
`default_nettype wire

// ==== mfr_host_model.sv ====
// host-side serial flash controller model
`timescale 1ns/10ps
`default_nettype none
module mfr_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [3:0] drv;
    logic [7:0] got [0:7];
    // undriven host lanes toggle so stale data never passes
    assign io_in = (io_oe & io_out) | (~io_oe & drv);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drv = 4'h0;
    end
    task automatic tick(input logic [3:0] d, output logic [3:0] s);
        sclk <= 1'b0;
        drv <= d;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
        s = io_in;
        @(posedge clk);
    endtask : tick
    task automatic send(input logic [23:0] v, input int n, input int w);
        logic [3:0] s;
        logic [23:0] r;
        r = v << (24 - n);
        for (int i = 0; i < n / w; i++) begin
            // msb first, junk on idle lanes single-line, zeros on idle lanes two-line
            tick((w == 1) ? {3'h5, r[23]} : r[23:20] >> (4 - w), s);
            r = r << w;
        end
    endtask : send
    task automatic frame(input logic [7:0] op, input int ow,
        input logic [23:0] a, input int na, input int aw,
        input logic [7:0] ind, input int ni, input int nd,
        input int dw, input int nb);
        logic [3:0] s;
        logic [7:0] b;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        if (ow != 0) send({16'h0000, op}, 8, ow); // opcode
        send(a, na, aw);
        if (ni != 0) send({16'h0000, ind}, 8, 4); // indicator
        repeat (nd) tick(~drv, s);
        for (int k = 0; k < nb; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8 / dw; j++) begin
                tick(~drv, s);
                b = (b << dw) | 8'(s & 4'((1 << dw) - 1));
            end
            got[k] = b;
        end
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1; // end after the last whole data byte
        repeat (12) @(posedge clk);
    endtask : frame
endmodule : mfr_host_model
`default_nettype wire

// ==== mfr_read_engine_bench.sv ====
// testbench of the multi-line read engine
`include "mfr_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module mfr_read_engine_bench;
    logic clk, arst_n, four_line_mode, write_busy, arr_rd_en, cs_n, sclk;
    logic [3:0] io_in, io_out, io_oe;
    logic [23:0] arr_rd_addr;
    logic [7:0] arr_rd_data = 8'h00;
    logic enhance_active, wrap_enable;
    int mismatches = 0;
    int check_count = 0;
    int oe_cnt = 0;
    localparam int AW [5] = '{1, 2, 1, 4, 4};
    localparam int NI [5] = '{0, 0, 0, 2, 2};
    localparam int ND [5] = '{8, 4, 8, 4, 2};
    localparam int DW [5] = '{2, 2, 4, 4, 4};
    mfr_read_engine dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
        .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .four_line_mode(four_line_mode), .write_busy(write_busy),
        .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
        .arr_rd_data(arr_rd_data), .enhance_active(enhance_active),
        .wrap_enable(wrap_enable));
    mfr_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    function automatic logic [7:0] ex(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h5A;
    endfunction : ex
    always @(posedge clk) begin
        if (arr_rd_en) arr_rd_data <= ex(arr_rd_addr);
        if (io_oe != 4'h0) oe_cnt <= oe_cnt + 1;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rd(input logic [7:0] op, input int ow,
        input logic [23:0] a, input int na, input int aw,
        input logic [7:0] ind, input int ni, input int nd, input int dw,
        input int nb);
        host.frame(op, ow, a, na, aw, ind, ni, nd, dw, nb);
        chk({4'h0, io_oe}, 8'h00);
    endtask : rd
    task automatic t_multi;
        logic [7:0] ops [0:4];
        ops = '{`MFR_OP_DUAL_OUT, 8'hBB, `MFR_OP_QUAD_OUT, `MFR_OP_QUAD_IO,
            `MFR_OP_QUAD_IO_SD};
        for (int i = 0; i < 5; i++) begin
            rd(ops[i], 1, 24'hFF_FFFE, 24, AW[i], 8'hFF, NI[i], ND[i], DW[i],
                4);
            for (int k = 0; k < 4; k++)
                chk(host.got[k], ex(24'(24'hFF_FFFE + k)));
            chk({7'h00, enhance_active}, 8'h00);
        end
        $display("test multi done");
    endtask : t_multi
    task automatic t_busy;
        int c;
        @(posedge clk) write_busy <= 1'b1;
        c = oe_cnt;
        rd(`MFR_OP_QUAD_OUT, 1, 24'h00_0123, 24, 1, 8'hFF, 0, 8, 4, 2);
        chk(8'(oe_cnt - c), 8'h00);
        @(posedge clk) write_busy <= 1'b0;
        $display("test busy done");
    endtask : t_busy
    task automatic t_enh;
        rd(`MFR_OP_QUAD_IO, 1, 24'h00_0040, 24, 4, 8'hA5, 2, 4, 4, 2);
        chk({7'h00, enhance_active}, 8'h01);
        rd(8'h00, 0, 24'h00_0080, 24, 4, 8'h5A, 2, 4, 4, 2);
        chk(host.got[1], ex(24'h00_0081));
        chk({7'h00, enhance_active}, 8'h01);
        rd(8'h00, 0, 24'h00_00C0, 24, 4, 8'h00, 2, 4, 4, 2);
        chk(host.got[0], ex(24'h00_00C0));
        chk({7'h00, enhance_active}, 8'h00);
        rd(`MFR_OP_QUAD_IO, 1, 24'h01_0010, 24, 4, 8'hF0, 2, 4, 4, 2);
        chk(host.got[0], ex(24'h01_0010));
        rd(8'h00, 0, 24'h01_0020, 24, 4, 8'hFF, 2, 4, 4, 2);
        chk(host.got[1], ex(24'h01_0021));
        chk({7'h00, enhance_active}, 8'h00);
        $display("test enhance done");
    endtask : t_enh
    task automatic t_wrap;
        logic [23:0] a;
        chk({7'h00, wrap_enable}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            rd(8'hC0, 1, 24'(c), 8, 1, 8'h00, 0, 0, 1, 0);
            chk({7'h00, wrap_enable}, 8'h01);
            a = 24'h00_0300 + 24'((8 << c) - 1);
            rd(`MFR_OP_QUAD_IO, 1, a, 24, 4, 8'hFF, 2, 4, 4, 2);
            chk(host.got[1], ex(24'h00_0300));
        end
        @(posedge clk) four_line_mode <= 1'b1;
        rd(8'hC0, 4, 24'h00_0000, 8, 4, 8'h00, 0, 0, 1, 0);
        rd(`MFR_OP_QUAD_IO, 4, 24'h00_0207, 24, 4, 8'hFF, 2, 4, 4, 2);
        chk(host.got[1], ex(24'h00_0200));
        rd(`MFR_OP_FAST, 4, 24'h00_010F, 24, 4, 8'hFF, 2, 2, 4, 2);
        chk(host.got[1], ex(24'h00_0108));
        rd(8'hC0, 4, 24'h00_0010, 8, 4, 8'h00, 0, 0, 1, 0);
        chk({7'h00, wrap_enable}, 8'h00);
        @(posedge clk) four_line_mode <= 1'b0;
        $display("test wrap done");
    endtask : t_wrap
    task automatic t_reset;
        rd(8'hC0, 1, 24'h00_0001, 8, 1, 8'h00, 0, 0, 1, 0);
        rd(`MFR_OP_QUAD_IO, 1, 24'h00_000F, 24, 4, 8'hA5, 2, 4, 4, 2);
        chk(host.got[1], ex(24'h00_0000));
        chk({7'h00, enhance_active}, 8'h01);
        @(posedge clk) arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk({7'h00, wrap_enable}, 8'h00);
        chk({7'h00, enhance_active}, 8'h00);
        rd(`MFR_OP_QUAD_IO, 1, 24'h00_0307, 24, 4, 8'hFF, 2, 4, 4, 2);
        chk(host.got[1], ex(24'h00_0308));
        $display("test reset done");
    endtask : t_reset
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0;
        four_line_mode = 1'b0;
        write_busy = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_wrap();
        t_multi();
        t_busy();
        t_enh();
        t_reset();
        finish_test();
    end
endmodule : mfr_read_engine_bench
`default_nettype wire
